/* File: hw/mpf_top.v */
/*
 Multifunction pin block: two general pins and one auxiliary line with a
 second marker pulse generator, a fix indicator and level or edge inputs.
 Assumes a 20 MHz clock, synchronous reset at power up and a classic
 Wishbone master that holds each request until ack.
*/
// The implementer's own choices: the Wishbone slave port and the address map.
// Notes on behaviour
// - Pulse high 50 ms each second
// - Start at 100 ms, always pulse
// - Time correction may shorten interval
// - Aux falls, general pins rise
// - Time valid flag readable by software
// - Fix pin high for 3D or better
// - Stationary input: high means rest
// - Receiver disabled while pin high
// - Pressure sensor disabled while pin high
// - Rising edge zeroes orientation alignment
// - Zero alignment lost at reset
// - Rising edge sends one status message
`timescale 1ns/10ps
`include "mpf_defines.vh"
module mpf_top #(
  parameter PERIOD_CYC = `MPF_PERIOD_CYC,
  parameter PULSE_CYC = `MPF_PULSE_CYC,
  parameter START_CYC = `MPF_START_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire time_corr_i,
  input wire gp1_i,
  output wire gp1_o,
  output wire gp1_oe_n_o,
  input wire gp2_i,
  output wire gp2_o,
  output wire gp2_oe_n_o,
  input wire aux_i,
  output wire aux_o,
  output wire aux_oe_n_o,
  output reg stationary_o,
  output reg sat_disable_o,
  output reg press_disable_o,
  output reg zero_align_o,
  output reg zero_pulse_o,
  output reg status_req_o
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [11:0] func;
  reg [2:0] fix_type;
  reg time_ok;
  reg [26:0] count;
  reg [26:0] start_cnt;
  reg running;
  reg marker;
  reg fix_ok;
  reg corr_req;
  wire [4:0] stat_v;
  wire [4:0] sat_v;
  wire [4:0] prs_v;
  wire [2:0] zero_v;
  wire [2:0] trig_v;
  wire [2:0] stat_w;
  wire [2:0] sat_w;
  wire [2:0] prs_w;
  wire acc;
  reg [31:0] next_dat;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [26:0] next_count;
  reg [26:0] next_start;

  localparam MK_WAIT = 2'h0;
  localparam MK_HIGH = 2'h1;
  localparam MK_LOW = 2'h2;

  // A held strobe is taken once: the raised ack blocks a second take
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function [7:0] mpf_lane;
    input [31:0] old_v;
    input [31:0] new_v;
    input sel;
    begin
      mpf_lane = sel ? new_v[7:0] : old_v[7:0];
    end
  endfunction

  // True in the last cycle of a count that starts at zero
  function mpf_reached;
    input [26:0] cnt_v;
    input [26:0] lim_v;
    begin
      mpf_reached = (cnt_v >= lim_v - 27'h0000001);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave, one wait-free cycle answer
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      func <= `MPF_FUNC_RST;
      {time_ok, fix_type} <= `MPF_STATE_RST;
      corr_req <= 1'b0;
    end else begin
      wb_ack_o <= acc;
      corr_req <= 1'b0;
      if (acc & ~wb_we_i) begin
        wb_dat_o <= next_dat;
      end
      if (acc & wb_we_i) begin
        case (wb_adr_i)
          `MPF_REG_FUNC: begin
            func[7:0] <= mpf_lane({20'h00000, func}, wb_dat_i, wb_sel_i[0]);
            if (wb_sel_i[1]) begin
              func[11:8] <= wb_dat_i[11:8];
            end
          end
          `MPF_REG_STATE: begin
            // Time valid is kept for software only; the marker never waits on it
            if (wb_sel_i[0]) begin
              fix_type <= wb_dat_i[`MPF_STATE_FIX_LSB +: 3];
              time_ok <= wb_dat_i[`MPF_STATE_TIMEOK_BIT];
            end
          end
          `MPF_REG_CORR: begin
            if (wb_sel_i[0]) begin
              corr_req <= wb_dat_i[`MPF_CORR_LSB];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------------
  // Unmapped offsets read as zero
  always @* begin
    next_dat = 32'h00000000;
    case (wb_adr_i)
      `MPF_REG_FUNC: next_dat = {20'h00000, func};
      `MPF_REG_STATE: next_dat = {28'h0000000, time_ok, fix_type};
      `MPF_REG_STATUS: begin
        next_dat[`MPF_ST_STAT_BIT] = stationary_o;
        next_dat[`MPF_ST_SATOFF_BIT] = sat_disable_o;
        next_dat[`MPF_ST_PRSOFF_BIT] = press_disable_o;
        next_dat[`MPF_ST_ZERO_BIT] = zero_align_o;
        next_dat[`MPF_ST_TRIG_BIT] = status_req_o;
        next_dat[`MPF_ST_RUN_BIT] = running;
      end
      default: next_dat = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Second marker generator
  // ----------------------------------------------------------------------
  // Once running, a correction reopens the high phase, so one interval may be short.
  // The start counter freezes once running; only a reset re-arms it.
  always @* begin
    next_state = state;
    next_count = count;
    next_start = start_cnt;
    case (state)
      MK_WAIT: begin
        if (mpf_reached(start_cnt, START_CYC[26:0])) begin
          next_state = MK_HIGH;
          next_count = 27'h0000000;
        end else begin
          next_start = start_cnt + 27'h0000001;
        end
      end
      MK_HIGH, MK_LOW: begin
        if (time_corr_i | corr_req) begin
          next_state = MK_HIGH;
          next_count = 27'h0000000;
        end else if (mpf_reached(count, PERIOD_CYC[26:0])) begin
          next_state = MK_HIGH;
          next_count = 27'h0000000;
        end else begin
          next_count = count + 27'h0000001;
          if (mpf_reached(count, PULSE_CYC[26:0])) begin
            next_state = MK_LOW;
          end
        end
      end
      default: begin
        // Unused code falls back to waiting
        next_state = MK_WAIT;
        next_count = 27'h0000000;
        next_start = 27'h0000000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Marker state register
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= MK_WAIT;
      start_cnt <= 27'h0000000;
      running <= 1'b0;
      count <= 27'h0000000;
      marker <= 1'b0;
    end else begin
      state <= next_state;
      start_cnt <= next_start;
      count <= next_count;
      // pulses whatever the time flag says
      running <= (next_state != MK_WAIT);
      marker <= (next_state == MK_HIGH);
    end
  end

  // ----------------------------------------------------------------------
  // Fix indicator
  // ----------------------------------------------------------------------
  // Registered, so the fix pin follows a state write after two cycles
  // 3D or better is a good fix
  always @(posedge clk_i) begin
    if (rst_i) begin
      fix_ok <= 1'b0;
    end else begin
      fix_ok <= (fix_type >= `MPF_FIX_3D);
    end
  end

  // ----------------------------------------------------------------------
  // Pin slices; aux inverts to mark the second on its falling edge
  // ----------------------------------------------------------------------
  mpf_pin #(.INVERT(0)) u_gp1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .func_i(func[`MPF_FUNC_P1_LSB +: 4]),
    .marker_i(marker),
    .fix_ok_i(fix_ok),
    .pin_i(gp1_i),
    .pin_o(gp1_o),
    .pin_oe_n_o(gp1_oe_n_o),
    .stat_o(stat_w[0]),
    .sat_off_o(sat_w[0]),
    .press_off_o(prs_w[0]),
    .zero_p_o(zero_v[0]),
    .trig_p_o(trig_v[0])
  );

  mpf_pin #(.INVERT(0)) u_gp2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .func_i(func[`MPF_FUNC_P2_LSB +: 4]),
    .marker_i(marker),
    .fix_ok_i(fix_ok),
    .pin_i(gp2_i),
    .pin_o(gp2_o),
    .pin_oe_n_o(gp2_oe_n_o),
    .stat_o(stat_w[1]),
    .sat_off_o(sat_w[1]),
    .press_off_o(prs_w[1]),
    .zero_p_o(zero_v[1]),
    .trig_p_o(trig_v[1])
  );

  mpf_pin #(.INVERT(1)) u_aux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .func_i(func[`MPF_FUNC_AUX_LSB +: 4]),
    .marker_i(marker),
    .fix_ok_i(fix_ok),
    .pin_i(aux_i),
    .pin_o(aux_o),
    .pin_oe_n_o(aux_oe_n_o),
    .stat_o(stat_w[2]),
    .sat_off_o(sat_w[2]),
    .press_off_o(prs_w[2]),
    .zero_p_o(zero_v[2]),
    .trig_p_o(trig_v[2])
  );

  assign stat_v = {2'b00, stat_w};
  assign sat_v = {2'b00, sat_w};
  assign prs_v = {2'b00, prs_w};

  // ----------------------------------------------------------------------
  // Combined function outputs
  // ----------------------------------------------------------------------
  // Pins sharing one input function are ORed together.
  // Alignment is volatile on purpose: only reset clears it.
  always @(posedge clk_i) begin
    if (rst_i) begin
      stationary_o <= 1'b0;
      sat_disable_o <= 1'b0;
      press_disable_o <= 1'b0;
      zero_pulse_o <= 1'b0;
      status_req_o <= 1'b0;
      zero_align_o <= 1'b0;
    end else begin
      stationary_o <= |stat_v;
      sat_disable_o <= |sat_v;
      press_disable_o <= |prs_v;
      zero_pulse_o <= |zero_v;
      status_req_o <= |trig_v;
      if (|zero_v) begin
        zero_align_o <= 1'b1;
      end
    end
  end
endmodule

/* File: hw/mpf_defines.vh */
/*
 Constants for the multifunction pin block: function codes, register map,
 field positions, reset values and timing figures.
 Assumes a 20 MHz system clock and a classic Wishbone register bus.
*/
`ifndef MPF_DEFINES_VH
`define MPF_DEFINES_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define MPF_CLK_HZ 20000000
`define MPF_PULSE_MS 50
`define MPF_START_MS 100
`define MPF_PERIOD_MS 1000
`define MPF_PULSE_CYC ((`MPF_CLK_HZ / 1000) * `MPF_PULSE_MS)
`define MPF_START_CYC ((`MPF_CLK_HZ / 1000) * `MPF_START_MS)
`define MPF_PERIOD_CYC ((`MPF_CLK_HZ / 1000) * `MPF_PERIOD_MS)

// ----------------------------------------------------------------------
// Pin function codes
// ----------------------------------------------------------------------
`define MPF_FN_INACTIVE 4'h0
`define MPF_FN_SECOND 4'h1
`define MPF_FN_FIX 4'h2
`define MPF_FN_STATIONARY 4'h3
`define MPF_FN_SAT_OFF 4'h4
`define MPF_FN_PRESS_OFF 4'h5
`define MPF_FN_ZERO_ORIENT 4'h6
`define MPF_FN_STATUS_TRIG 4'h7

// ----------------------------------------------------------------------
// Fix type codes
// ----------------------------------------------------------------------
`define MPF_FIX_NONE 3'h0
`define MPF_FIX_2D 3'h1
`define MPF_FIX_3D 3'h2

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define MPF_REG_FUNC 4'h0
`define MPF_REG_STATE 4'h4
`define MPF_REG_STATUS 4'h8
`define MPF_REG_CORR 4'hC

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MPF_FUNC_P1_LSB 0
`define MPF_FUNC_P2_LSB 4
`define MPF_FUNC_AUX_LSB 8
`define MPF_STATE_FIX_LSB 0
`define MPF_STATE_TIMEOK_BIT 3
`define MPF_CORR_LSB 0
`define MPF_ST_STAT_BIT 0
`define MPF_ST_SATOFF_BIT 1
`define MPF_ST_PRSOFF_BIT 2
`define MPF_ST_ZERO_BIT 3
`define MPF_ST_TRIG_BIT 4
`define MPF_ST_RUN_BIT 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MPF_FUNC_RST 12'h000
`define MPF_STATE_RST 4'h0

`endif

/* File: hw/mpf_sync.v */
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes the input is asynchronous to clk_i; output changes only once
 the second and third stages agree.
*/
`timescale 1ns/10ps
module mpf_sync (
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule

/* File: hw/mpf_pin.v */
/*
 One multifunction pin slice: drives the selected output function and
 decodes the selected input function from the synchronised pin.
 Assumes shared second marker and fix indication from the top.
*/
`timescale 1ns/10ps
`include "mpf_defines.vh"
module mpf_pin #(
  parameter INVERT = 0
) (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] func_i,
  input wire marker_i,
  input wire fix_ok_i,
  input wire pin_i,
  output reg pin_o,
  output reg pin_oe_n_o,
  output reg stat_o,
  output reg sat_off_o,
  output reg press_off_o,
  output reg zero_p_o,
  output reg trig_p_o
);
  wire lvl;
  reg lvl_d;
  wire rise;

  mpf_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_i),
    .level_o(lvl)
  );

  assign rise = lvl & ~lvl_d;

  always @(posedge clk_i) begin
    if (rst_i) begin
      lvl_d <= 1'b1;
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
      stat_o <= 1'b0;
      sat_off_o <= 1'b0;
      press_off_o <= 1'b0;
      zero_p_o <= 1'b0;
      trig_p_o <= 1'b0;
    end else begin
      lvl_d <= lvl;
      case (func_i)
        `MPF_FN_SECOND: begin
          pin_o <= (INVERT != 0) ? ~marker_i : marker_i;
          pin_oe_n_o <= 1'b0;
        end
        `MPF_FN_FIX: begin
          pin_o <= fix_ok_i;
          pin_oe_n_o <= 1'b0;
        end
        default: begin
          pin_o <= 1'b0;
          pin_oe_n_o <= 1'b1;
        end
      endcase
      stat_o <= (func_i == `MPF_FN_STATIONARY) & lvl;
      sat_off_o <= (func_i == `MPF_FN_SAT_OFF) & lvl;
      press_off_o <= (func_i == `MPF_FN_PRESS_OFF) & lvl;
      zero_p_o <= (func_i == `MPF_FN_ZERO_ORIENT) & rise;
      trig_p_o <= (func_i == `MPF_FN_STATUS_TRIG) & rise;
    end
  end
endmodule

/* File: test/mpf_top_monitor.sv */
/* Port checker for mpf_top.
 Assumes it is bound to mpf_top and sees only its ports. */
`timescale 1ns/10ps
module mpf_top_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire gp1_i,
  input wire gp2_i,
  input wire aux_i,
  input wire gp1_oe_n_o,
  input wire gp2_oe_n_o,
  input wire aux_oe_n_o,
  input wire stationary_o,
  input wire sat_disable_o,
  input wire press_disable_o,
  input wire zero_align_o,
  input wire zero_pulse_o,
  input wire status_req_o
);
  wire any_pin = gp1_i | gp2_i | aux_i;
  wire any_tri = gp1_oe_n_o | gp2_oe_n_o | aux_oe_n_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // Checks
  // ----
  AST_ZERO_HOLD: assert property (zero_align_o |=> zero_align_o)
    else $error("zero align dropped");
  AST_ZERO_SET: assert property (zero_pulse_o |=> zero_align_o)
    else $error("zero align not set");
  AST_ZERO_CAUSE: assert property ($rose(zero_align_o) |-> zero_pulse_o || $past(zero_pulse_o))
    else $error("zero align without pulse");
  AST_ZERO_ONE: assert property (zero_pulse_o |=> !zero_pulse_o)
    else $error("zero pulse too long");
  AST_TRIG_ONE: assert property (status_req_o |=> !status_req_o)
    else $error("status pulse too long");
  AST_EDGE_CAUSE: assert property ((zero_pulse_o || status_req_o) |-> $past(any_pin, 2))
    else $error("edge pulse without high pin");
  AST_IN_TRI: assert property ((stationary_o || sat_disable_o || press_disable_o) |-> any_tri)
    else $error("input level with all pins driven");
  AST_STAT_RISE: assert property ($rose(stationary_o) |-> $past(any_pin, 2))
    else $error("rest flag without high pin");
  AST_SAT_RISE: assert property ($rose(sat_disable_o) |-> $past(any_pin, 2))
    else $error("receiver off without high pin");
  AST_PRS_RISE: assert property ($rose(press_disable_o) |-> $past(any_pin, 2))
    else $error("pressure off without high pin");
endmodule
bind mpf_top mpf_top_monitor u_mpf_top_monitor (.clk_i(clk_i), .rst_i(rst_i), .gp1_i(gp1_i),
  .gp2_i(gp2_i), .aux_i(aux_i), .gp1_oe_n_o(gp1_oe_n_o), .gp2_oe_n_o(gp2_oe_n_o),
  .aux_oe_n_o(aux_oe_n_o), .stationary_o(stationary_o), .sat_disable_o(sat_disable_o),
  .press_disable_o(press_disable_o), .zero_align_o(zero_align_o),
  .zero_pulse_o(zero_pulse_o), .status_req_o(status_req_o));

/* File: test/mpf_sw_model.sv */
/* Switch and equipment model on the pin side of mpf_top.
 Assumes the bench sets raw switch levels on sw_i. */
`timescale 1ns/10ps
module mpf_sw_model (
  input wire clk_i,
  input wire [2:0] sw_i,
  input wire [2:0] dout_i,
  input wire [2:0] oe_n_i,
  output wire [2:0] pin_o
);
  reg [2:0] last = 3'h0;
  reg [2:0] clean = 3'h0;
  reg [2:0] hold = 3'h0;
  always @(posedge clk_i) begin
    last <= sw_i;
    if (sw_i != last) begin
      hold <= 3'h0;
    end else if (hold != 3'h7) begin
      hold <= hold + 3'h1;
    end else begin
      clean <= last;
    end
  end
  // wire level, design wins when driving
  assign pin_o = (~oe_n_i & dout_i) | (oe_n_i & clean);
endmodule

/* File: test/mpf_top_test.sv */
/* Bench for mpf_top: Wishbone tasks, pin model and self-checks.
 Assumes mpf_defines.vh is on the include path. */
`timescale 1ns/10ps
`include "mpf_defines.vh"
module mpf_top_test;
  localparam PER = 200;
  localparam PUL = 50;
  localparam STA = 100;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, corr = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [31:0] dat = 32'h0, rv;
  reg [2:0] sw = 3'h0;
  wire [31:0] rdat;
  wire [2:0] po, poe, pin;
  wire ack, stat, sat, prs, zal, zp, sr;
  integer failures = 0, check_count = 0, tmo = 0, c = 0, n, k, zc, sc;
  mpf_top #(.PERIOD_CYC(PER), .PULSE_CYC(PUL), .START_CYC(STA)) u_mpf_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .time_corr_i(corr), .gp1_i(pin[0]), .gp1_o(po[0]), .gp1_oe_n_o(poe[0]),
    .gp2_i(pin[1]), .gp2_o(po[1]), .gp2_oe_n_o(poe[1]), .aux_i(pin[2]), .aux_o(po[2]),
    .aux_oe_n_o(poe[2]), .stationary_o(stat), .sat_disable_o(sat),
    .press_disable_o(prs), .zero_align_o(zal), .zero_pulse_o(zp), .status_req_o(sr));
  mpf_sw_model u_mpf_sw_model (.clk_i(clk_i), .sw_i(sw), .dout_i(po), .oe_n_i(poe),
    .pin_o(pin));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    c <= rst_i ? 0 : c + 1;
    tmo <= tmo + 1;
    if (tmo == 10000) begin
      failures = failures + 1;
      wrap_up;
    end
  end
  // ----
  // Tasks
  // ----
  task wrap_up;
    begin
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("[FAIL] %0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task tick(input integer m);
    repeat (m) @(posedge clk_i);
  endtask
  // Request held until the ack edge, then released for a cycle
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      rv = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task cnt(input integer b, input v);
    begin
      n = 0;
      while (po[b] === v) begin
        @(posedge clk_i);
        n = n + 1;
      end
    end
  endtask
  task press(input [2:0] v);
    begin
      sw <= v;
      zc = 0;
      sc = 0;
      repeat (30) begin
        @(posedge clk_i);
        zc = zc + zp;
        sc = sc + sr;
      end
    end
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    tick(16);
    rst_i <= 1'b0;
    tick(1);
    chk(poe, 32'h7);
    bus(1'b0, `MPF_REG_FUNC, 32'h0);
    chk(rv, 32'h0);
    bus(1'b0, 4'h1, 32'h0);
    chk(rv, 32'h0);
    bus(1'b1, `MPF_REG_FUNC, 32'h121);
    cnt(0, 1'b0);
    chk(c >= STA && c <= STA + 4, 32'h1);
    chk(po[2], 32'h0);
    cnt(0, 1'b1);
    chk(n, PUL);
    chk(po[2], 32'h1);
    cnt(0, 1'b0);
    chk(n, PER - PUL);
    for (k = 0; k < 2; k = k + 1) begin
      tick(60);
      if (k == 0) begin
        corr <= 1'b1;
        tick(1);
        corr <= 1'b0;
      end else begin
        bus(1'b1, `MPF_REG_CORR, 32'h1);
      end
      cnt(0, 1'b0);
      chk(n <= 6, 32'h1);
    end
    for (k = 0; k < 4; k = k + 1) begin
      bus(1'b1, `MPF_REG_STATE, k);
      tick(3);
      chk(po[1], k >= 2);
    end
    bus(1'b1, `MPF_REG_STATE, 32'hA);
    bus(1'b0, `MPF_REG_STATE, 32'h0);
    chk(rv, 32'hA);
    bus(1'b1, `MPF_REG_FUNC, 32'h543);
    tick(2);
    chk(poe, 32'h7);
    for (k = 0; k < 8; k = k + 1) begin
      sw <= k;
      tick(24);
      chk({prs, sat, stat}, k);
    end
    bus(1'b0, `MPF_REG_STATUS, 32'h0);
    chk(rv[5:0], 32'h27);
    sw <= 3'h0;
    tick(24);
    bus(1'b1, `MPF_REG_FUNC, 32'h76);
    chk(zal, 32'h0);
    press(3'h1);
    chk(zc * 16 + sc, 32'h10);
    chk(zal, 32'h1);
    press(3'h3);
    chk(zc * 16 + sc, 32'h1);
    press(3'h0);
    chk(zc * 16 + sc, 32'h0);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(2);
    chk(zal, 32'h0);
    wrap_up;
  end
endmodule
